// ===== hw/cordic_pkg.sv
package cordic_pkg;

  localparam int          XW        = 26;
  localparam int          ZW        = 21;
  localparam logic [15:0] OP_RST    = 16'h0000;
  localparam logic [7:0]  RD_RST    = 8'h00;
  localparam logic [3:0]  IT_FIRST  = 4'h0;
  localparam logic [3:0]  IT_LAST   = 4'hf;
  localparam logic [5:0]  LAT_MAX   = 6'h29;
  localparam logic [1:0]  SEL_X     = 2'h0;
  localparam logic [1:0]  SEL_Y     = 2'h1;
  localparam logic [1:0]  SEL_Z     = 2'h2;
  localparam logic [19:0] LIN_ONE   = 20'h08000;
  localparam logic [20:0] PI_Z      = 21'h080000;
  localparam logic [20:0] HALF_PI_Z = 21'h040000;

  // Arctangent steps, pi maps to 2^19.
  localparam logic [19:0] ATAN_TAB [16] = '{
    20'h20000, 20'h12e40, 20'h09fb3, 20'h05111,
    20'h028b0, 20'h0145d, 20'h00a2f, 20'h00517,
    20'h0028b, 20'h00145, 20'h000a2, 20'h00051,
    20'h00028, 20'h00014, 20'h0000a, 20'h00005};

  // Hyperbolic steps by shift; shift zero is never used.
  localparam logic [19:0] ATANH_TAB [16] = '{
    20'h00000, 20'h16616, 20'h0a681, 20'h051ea,
    20'h028cc, 20'h01460, 20'h00a2f, 20'h00517,
    20'h0028b, 20'h00145, 20'h000a2, 20'h00051,
    20'h00028, 20'h00014, 20'h0000a, 20'h00005};

  typedef enum logic [1:0] {
    MODE_CIRC = 2'h0,
    MODE_LIN  = 2'h1,
    MODE_HYP  = 2'h2
  } cmode_t;

  typedef enum logic [2:0] {
    FSM_IDLE = 3'b001,
    FSM_RUN  = 3'b010,
    FSM_DONE = 3'b100
  } fsm_t;

  typedef struct packed {
    cmode_t mode;
    logic   vectoring;
    logic   keep_x;
    logic   keep_y;
    logic   keep_z;
    logic   x_unsigned;
    logic   int_en;
  } ctrl_t;

  typedef struct packed {
    logic       en;
    logic [1:0] sel;
    logic       hi;
    logic [7:0] data;
  } byte_wr_t;

  typedef struct packed {
    fsm_t          fsm;
    logic [3:0]    it;
    ctrl_t         cfg;
    logic [15:0]   xo;
    logic [15:0]   yo;
    logic [15:0]   zo;
    logic [XW-1:0] x;
    logic [XW-1:0] y;
    logic [ZW-1:0] z;
    logic          busy;
    logic          done;
    logic          irq;
    logic [7:0]    rd;
  } state_t;

endpackage

// ===== hw/cordic_coprocessor.sv
module cordic_coprocessor
  import cordic_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       module_en,
  input  wire ctrl_t      ctrl,
  input  wire logic       launch,
  input  wire logic       flag_clear,
  input  wire byte_wr_t   wr,
  input  wire logic [1:0] rd_sel,
  input  wire logic       rd_hi,
  output logic      [7:0] rd_data,
  output logic            busy,
  output logic            done_flag,
  output logic            irq
);

  state_t r_reg;
  state_t r_next;

  // Hyperbolic shifts repeat 4 and 13 so the series converges.
  function automatic logic [3:0] hyp_shift(input logic [3:0] it);
    if (it < 4'h4) begin
      hyp_shift = it + 4'h1;
    end else if (it < 4'he) begin
      hyp_shift = it;
    end else begin
      hyp_shift = it - 4'h1;
    end
  endfunction

  function automatic logic [19:0] step_angle(input cmode_t m,
                                             input logic [3:0] s);
    case (m)
      MODE_LIN: step_angle = LIN_ONE >> s;
      MODE_HYP: step_angle = ATANH_TAB[s];
      default:  step_angle = ATAN_TAB[s];
    endcase
  endfunction

  // Saturates the 26-bit kernel into 16 result bits.
  function automatic logic [15:0] sat16(input logic [XW-1:0] v,
                                        input logic uns);
    sat16 = v[23:8];
    if (uns) begin
      if (v[25]) begin
        sat16 = 16'h0000;
      end else if (v[24]) begin
        sat16 = 16'hffff;
      end
    end else if (v[25:23] != 3'b000 && v[25:23] != 3'b111) begin
      sat16 = v[25] ? 16'h8000 : 16'h7fff;
    end
  endfunction

  function automatic logic [15:0] pick(input logic [15:0] v,
                                       input logic [1:0] sel,
                                       input logic hi,
                                       input logic [1:0] me,
                                       input logic [7:0] d);
    pick = v;
    if (sel == me) begin
      if (hi) begin
        pick[15:8] = d;
      end else begin
        pick[7:0] = d;
      end
    end
  endfunction

  logic signed [XW-1:0] kx;
  logic signed [XW-1:0] ky;
  logic signed [ZW-1:0] kz;
  logic signed [XW-1:0] lx;
  logic signed [XW-1:0] ly;
  logic signed [ZW-1:0] lz;
  logic signed [XW-1:0] xs;
  logic signed [XW-1:0] ys;
  logic signed [ZW-1:0] ez;
  logic        [3:0]    sh;
  logic        [15:0]   res;
  logic                 dpos;
  logic                 accept;

  always_comb begin
    r_next = r_reg;
    kx     = signed'(r_reg.x);
    ky     = signed'(r_reg.y);
    kz     = signed'(r_reg.z);
    accept = launch && module_en && r_reg.fsm == FSM_IDLE;
    r_next.xo = pick(r_reg.xo, wr.sel, wr.hi, SEL_X, wr.data);
    r_next.yo = pick(r_reg.yo, wr.sel, wr.hi, SEL_Y, wr.data);
    r_next.zo = pick(r_reg.zo, wr.sel, wr.hi, SEL_Z, wr.data);
    if (!wr.en) begin
      r_next.xo = r_reg.xo;
      r_next.yo = r_reg.yo;
      r_next.zo = r_reg.zo;
    end
    lx = ctrl.keep_x ? kx : XW'({{2{r_reg.xo[15]}}, r_reg.xo, 8'h00});
    ly = ctrl.keep_y ? ky : XW'({{2{r_reg.yo[15]}}, r_reg.yo, 8'h00});
    lz = ctrl.keep_z ? kz : ZW'({r_reg.zo[15], r_reg.zo, 4'h0});
    // Turning by pi first keeps every start angle within reach of the steps.
    // circular pre-rotation, vectoring and rotation
    if (ctrl.mode != MODE_LIN && ctrl.mode != MODE_HYP) begin
      if (ctrl.vectoring && lx < 0) begin
        lx = -lx;
        ly = -ly;
        lz = lz - signed'(PI_Z);
      end else if (!ctrl.vectoring && lz > signed'(HALF_PI_Z)) begin
        lx = -lx;
        ly = -ly;
        lz = lz - signed'(PI_Z);
      end else if (!ctrl.vectoring && lz < -signed'(HALF_PI_Z)) begin
        lx = -lx;
        ly = -ly;
        lz = lz + signed'(PI_Z);
      end
    end
    sh   = (r_reg.cfg.mode == MODE_HYP) ? hyp_shift(r_reg.it)
                                         : r_reg.it;
    ez   = signed'({1'b0, step_angle(r_reg.cfg.mode, sh)});
    xs   = kx >>> sh;
    ys   = ky >>> sh;
    dpos = r_reg.cfg.vectoring ? ky < 0 : !kz[ZW-1];
    case (rd_sel)
      SEL_X:   res = sat16(r_reg.x, r_reg.cfg.x_unsigned);
      SEL_Y:   res = sat16(r_reg.y, 1'b0);
      SEL_Z:   res = r_reg.z[19:4];
      default: res = OP_RST;
    endcase
    r_next.rd = rd_hi ? res[15:8] : res[7:0];
    if (flag_clear) begin
      r_next.done = 1'b0;
    end
    if (module_en) begin
      case (r_reg.fsm)
        FSM_IDLE: begin
          if (launch) begin
            r_next.cfg  = ctrl;
            r_next.x    = lx;
            r_next.y    = ly;
            r_next.z    = lz;
            r_next.it   = IT_FIRST;
            r_next.busy = 1'b1;
            r_next.done = 1'b0;
            r_next.fsm  = FSM_RUN;
          end
        end
        FSM_RUN: begin
          if (dpos) begin
            r_next.y = ky + xs;
            r_next.z = kz - ez;
          end else begin
            r_next.y = ky - xs;
            r_next.z = kz + ez;
          end
          if (r_reg.cfg.mode == MODE_HYP) begin
            r_next.x = dpos ? kx + ys : kx - ys;
          end else if (r_reg.cfg.mode != MODE_LIN) begin
            r_next.x = dpos ? kx - ys : kx + ys;
          end
          r_next.it = r_reg.it + 4'h1;
          if (r_reg.it == IT_LAST) begin
            r_next.fsm = FSM_DONE;
          end
        end
        FSM_DONE: begin
          r_next.done = 1'b1;
          r_next.busy = 1'b0;
          r_next.fsm  = FSM_IDLE;
        end
        default: begin
          r_next.fsm  = FSM_IDLE;
          r_next.busy = 1'b0;
        end
      endcase
    end
    r_next.irq = r_next.done && ctrl.int_en;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r_reg <= '{fsm: FSM_IDLE, it: IT_FIRST, cfg: '0,
                 xo: OP_RST, yo: OP_RST, zo: OP_RST,
                 x: '0, y: '0, z: '0, busy: 1'b0,
                 done: 1'b0, irq: 1'b0, rd: RD_RST};
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data   = r_reg.rd;
  assign busy      = r_reg.busy;
  assign done_flag = r_reg.done;
  assign irq       = r_reg.irq;

  // Counts enabled cycles of a calculation, for checking only.
  logic [5:0] lat_q;

  always_ff @(posedge sys_clk) begin
    if (reset || accept) begin
      lat_q <= 6'h01;
    end else if (r_reg.busy && module_en) begin
      lat_q <= lat_q + 6'h01;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_launch_busy;
    accept |=> busy && r_reg.fsm == FSM_RUN && r_reg.it == IT_FIRST;
  endproperty
  a_launch_busy: assert property (p_launch_busy)
    else $error("launch not taken");

  property p_sixteen;
    (r_reg.fsm == FSM_RUN && module_en) [*8] ##1
    (r_reg.fsm == FSM_RUN && module_en) [*8] |=> r_reg.fsm == FSM_DONE;
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("iteration count wrong");

  property p_latency;
    busy |-> lat_q <= LAT_MAX;
  endproperty
  a_latency: assert property (p_latency)
    else $error("calculation too slow");

  property p_flag;
    r_reg.fsm == FSM_DONE && module_en |=> done_flag && !busy;
  endproperty
  a_flag: assert property (p_flag)
    else $error("completion flag missing");

  property p_irq_gate;
    irq |-> done_flag && $past(ctrl.int_en);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without enable");

  // A launch drops the flag, and the request with it, at once.
  property p_irq_set;
    done_flag && !flag_clear && !accept && ctrl.int_en |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("enabled interrupt missing");

  property p_freeze;
    !module_en |=> r_reg.fsm == $past(r_reg.fsm) && r_reg.x == $past(r_reg.x);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("disabled block moved");

  property p_keep_x;
    accept && ctrl.keep_x && ctrl.mode == MODE_LIN |=>
      r_reg.x == $past(r_reg.x);
  endproperty
  a_keep_x: assert property (p_keep_x)
    else $error("kept X was reloaded");

  property p_load_z;
    accept && !ctrl.keep_z && ctrl.mode == MODE_LIN |=>
      r_reg.z[19:4] == $past(r_reg.zo) && r_reg.z[3:0] == 4'h0;
  endproperty
  a_load_z: assert property (p_load_z)
    else $error("Z operand load wrong");

  property p_lin_x;
    r_reg.fsm == FSM_RUN && r_reg.cfg.mode == MODE_LIN |=>
      r_reg.x == $past(r_reg.x);
  endproperty
  a_lin_x: assert property (p_lin_x)
    else $error("linear mode changed X");

  property p_rd_z;
    rd_sel == SEL_Z && !rd_hi |=> rd_data == $past(r_reg.z[11:4]);
  endproperty
  a_rd_z: assert property (p_rd_z)
    else $error("Z low byte read wrong");

  property p_clear;
    flag_clear && !(r_reg.fsm == FSM_DONE && module_en) |=> !done_flag;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag clear ignored");

  property p_done_idle;
    done_flag |-> !busy;
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("flag set while busy");

  property p_gate_launch;
    launch && !module_en && !busy |=> !busy;
  endproperty
  a_gate_launch: assert property (p_gate_launch)
    else $error("launch taken while disabled");

  c_circ_rot: cover property (accept && ctrl.mode == MODE_CIRC
                              && !ctrl.vectoring ##[18:40] done_flag);
  c_circ_vec: cover property (accept && ctrl.vectoring
                              && ctrl.mode == MODE_CIRC ##[18:40] irq);
  c_hyp: cover property (accept && ctrl.mode == MODE_HYP
                         ##[18:40] done_flag);
  c_keep: cover property (accept && ctrl.keep_x && ctrl.keep_y);

endmodule

// ===== testbench/cordic_host.sv
module cordic_host
  import cordic_pkg::*;
(
  input  wire logic       sys_clk,
  output logic            module_en,
  output ctrl_t           ctrl,
  output logic            launch,
  output logic            flag_clear,
  output byte_wr_t        wr,
  output logic      [1:0] rd_sel,
  output logic            rd_hi,
  input  wire logic [7:0] rd_data,
  input  wire logic       done_flag,
  output logic     [15:0] res,
  output logic            res_v
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    module_en = 1'b1;
    ctrl = '0;
    launch = 1'b0;
    flag_clear = 1'b0;
    wr = '0;
    rd_sel = 2'h3;
    rd_hi = 1'b0;
    res = '0;
    res_v = 1'b0;
  end

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // X and Y are written alike; only X can read back unsigned.
  task automatic wr16(input logic [1:0] s, input logic [15:0] v);
    tick();
    wr = '{1'b1, s, 1'b0, v[7:0]};
    tick();
    wr.hi = 1'b1;
    wr.data = v[15:8];
    tick();
    // A released data bus shows no stale byte.
    wr.en = 1'b0;
    wr.data = ~v[15:8];
  endtask

  task automatic rd16(input logic [1:0] s);
    tick();
    rd_sel = s;
    rd_hi = 1'b0;
    tick();
    res[7:0] = rd_data;
    rd_hi = 1'b1;
    tick();
    res[15:8] = rd_data;
    res_v = 1'b1;
    tick();
    res_v = 1'b0;
  endtask

  // Launch only after operands, read only after the flag.
  task automatic go(input ctrl_t c, output int n);
    tick();
    ctrl = c;
    launch = 1'b1;
    tick();
    launch = 1'b0;
    n = 1;
    while (done_flag !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
  endtask
endmodule

// ===== testbench/cordic_coprocessor_tb.sv
module cordic_coprocessor_tb;
  import cordic_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {string n; logic [15:0] e; int tol;} note_t;
  note_t       notes[$];
  int          failures;
  int          n_compared;
  int          cyc;
  int          lat;
  logic        sys_clk;
  logic        reset;
  logic        module_en;
  ctrl_t       ctrl;
  logic        launch;
  logic        flag_clear;
  byte_wr_t    wr;
  logic [1:0]  rd_sel;
  logic        rd_hi;
  logic [7:0]  rd_data;
  logic        busy;
  logic        done_flag;
  logic        irq;
  logic [15:0] res;
  logic        res_v;
  logic [15:0] rx;

  cordic_host h (.sys_clk(sys_clk), .module_en(module_en), .ctrl(ctrl),
    .launch(launch), .flag_clear(flag_clear), .wr(wr), .rd_sel(rd_sel),
    .rd_hi(rd_hi), .rd_data(rd_data), .done_flag(done_flag), .res(res),
    .res_v(res_v));
  cordic_coprocessor dut (.sys_clk(sys_clk), .reset(reset),
    .module_en(module_en), .ctrl(ctrl), .launch(launch),
    .flag_clear(flag_clear), .wr(wr), .rd_sel(rd_sel), .rd_hi(rd_hi),
    .rd_data(rd_data), .busy(busy), .done_flag(done_flag), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask

  // Truncation allows a small error, so results carry a tolerance.
  task automatic cmp_val(input note_t t, input logic [15:0] g);
    int d;
    d = int'($signed(g)) - int'($signed(t.e));
    n_compared++;
    if ((t.tol == 0 && g !== t.e) || $isunknown(g) || d > t.tol
        || -d > t.tol) begin
      failures++;
      $display("ERROR %s expected %h seen %h", t.n, t.e, g);
    end
  endtask

  always @(posedge sys_clk) begin
    if (res_v === 1'b1)
      cmp_val(notes.pop_front(), res);
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic exp_rd(input string n, input logic [1:0] s,
                        input logic [15:0] e, input int tol);
    notes.push_back('{n, e, tol});
    h.rd16(s);
  endtask

  function automatic ctrl_t cf(cmode_t m, logic v, logic [4:0] b);
    ctrl_t c;
    c.mode = m;
    c.vectoring = v;
    {c.keep_x, c.keep_y, c.keep_z, c.x_unsigned, c.int_en} = b;
    return c;
  endfunction

  task automatic run(input ctrl_t c);
    h.go(c, lat);
    cmp_bit("latency", 1'b1, lat <= int'(LAT_MAX));
  endtask

  task automatic ops(input logic [15:0] x, y, z);
    h.wr16(SEL_X, x);
    h.wr16(SEL_Y, y);
    h.wr16(SEL_Z, z);
  endtask

  initial begin
    reset = 1'b1;
    void'($urandom(32'h724d0294));
    repeat (20) @(posedge sys_clk);
    #1 reset = 1'b0;
    cmp_bit("busy", 1'b0, busy);
    cmp_bit("done", 1'b0, done_flag);
    exp_rd("x_rst", SEL_X, 16'h0000, 0);
    rx = 16'($urandom);
    rx[15] = 1'b1;
    ops(rx, 16'h0000, 16'h0000);
    run(cf(MODE_LIN, 1'b0, 5'h00));
    exp_rd("x_signed", SEL_X, rx, 0);
    run(cf(MODE_LIN, 1'b0, 5'h02));
    exp_rd("x_unsigned", SEL_X, 16'h0000, 0);
    ops(16'h7fff, 16'h0000, 16'h0000);
    run(cf(MODE_CIRC, 1'b1, 5'h02));
    exp_rd("x_uns_big", SEL_X, 16'hd2c7, 8);
    ops(16'h0400, 16'h0010, 16'h0400);
    run(cf(MODE_LIN, 1'b0, 5'h00));
    exp_rd("lin_y", SEL_Y, 16'h0210, 2);
    exp_rd("lin_z", SEL_Z, 16'h0000, 2);
    run(cf(MODE_LIN, 1'b0, 5'h18));
    exp_rd("keep_y", SEL_Y, 16'h0410, 4);
    ops(16'h0400, 16'h0200, 16'h0000);
    run(cf(MODE_LIN, 1'b1, 5'h00));
    exp_rd("div_z", SEL_Z, 16'h0400, 2);
    ops(16'h2000, 16'h2000, 16'h0000);
    run(cf(MODE_CIRC, 1'b1, 5'h01));
    exp_rd("vec_z", SEL_Z, 16'h2000, 4);
    exp_rd("vec_x", SEL_X, 16'h4a86, 8);
    ops(16'h8000, 16'h7fff, 16'h0000);
    run(cf(MODE_CIRC, 1'b1, 5'h00));
    exp_rd("vec_full_z", SEL_Z, 16'h6000, 8);
    ops(16'h2000, 16'h0000, 16'h6000);
    run(cf(MODE_CIRC, 1'b0, 5'h00));
    exp_rd("rot_x", SEL_X, 16'hdabd, 8);
    exp_rd("rot_y", SEL_Y, 16'h2543, 8);
    ops(16'h4000, 16'h2000, 16'h0000);
    run(cf(MODE_HYP, 1'b1, 5'h01));
    h.tick();
    cmp_bit("irq_on", 1'b1, irq);
    exp_rd("hyp_z", SEL_Z, 16'h1661, 8);
    exp_rd("hyp_x", SEL_X, 16'h2de8, 8);
    h.tick();
    h.flag_clear = 1'b1;
    h.tick();
    h.flag_clear = 1'b0;
    cmp_bit("clr_done", 1'b0, done_flag);
    h.tick();
    cmp_bit("clr_irq", 1'b0, irq);
    run(cf(MODE_CIRC, 1'b0, 5'h00));
    h.tick();
    cmp_bit("irq_masked", 1'b0, irq);
    h.module_en = 1'b0;
    h.tick();
    h.launch = 1'b1;
    h.tick();
    h.launch = 1'b0;
    h.tick();
    cmp_bit("gated", 1'b0, busy);
    h.module_en = 1'b1;
    h.tick();
    cmp_bit("gated_hold", 1'b0, busy);
    // A run frozen after three of its sixteen steps must resume and still give the right sum.
    fork
      run(cf(MODE_LIN, 1'b0, 5'h00));
      begin
        repeat (5) h.tick();
        h.module_en = 1'b0;
        repeat (10) h.tick();
        cmp_bit("frozen_busy", 1'b1, busy);
        cmp_bit("frozen_done", 1'b0, done_flag);
        h.module_en = 1'b1;
      end
    join
    exp_rd("frozen_y", SEL_Y, 16'h2000, 4);
    close_out();
  end
endmodule
